/* File: core/bsfie_pkg.sv */
// package: opcodes, flag positions, register map and cycle counts
package bsfie_pkg;

  // command opcodes written into the command register
  typedef enum logic [4:0] {
    OP_NOP                  = 5'h00,
    OP_PUSH                 = 5'h01,
    OP_POP                  = 5'h02,
    OP_SET_IO_BIT           = 5'h03,
    OP_CLEAR_IO_BIT         = 5'h04,
    OP_SHIFT_LEFT_LOGICAL   = 5'h05,
    OP_SHIFT_RIGHT_LOGICAL  = 5'h06,
    OP_ROTATE_LEFT_CARRY    = 5'h07,
    OP_ROTATE_RIGHT_CARRY   = 5'h08,
    OP_ARITH_SHIFT_RIGHT    = 5'h09,
    OP_SWAP_NIBBLES         = 5'h0A,
    OP_STORE_BIT_TO_FLAG    = 5'h0B,
    OP_LOAD_BIT_FROM_FLAG   = 5'h0C,
    OP_FLAG_SET             = 5'h0D,
    OP_FLAG_CLEAR           = 5'h0E,
    OP_SLEEP                = 5'h0F,
    OP_WATCHDOG_KICK        = 5'h10,
    OP_BREAK                = 5'h11
  } bsfie_op_e;

  // bit positions inside the status flag register
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // byte offsets on the bus, and page numbers held in address bits 11:8
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_SP = 12'h00C;
  localparam logic [3:0] PAGE_REGS = 4'h1;
  localparam logic [3:0] PAGE_IO = 4'h2;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_RD_LSB = 8;
  localparam int CMD_BIT_LSB = 16;
  localparam int CMD_IO_LSB = 24;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_HALT = 1;

  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;

  // execution lengths in clock cycles
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

endpackage

/* File: core/bsfie_alu_if.sv */
// interface: operands and results between the core and its bit/shift unit
`timescale 1ns/100ps
`default_nettype none
interface bsfie_alu_if;
  logic [4:0] op;
  logic [7:0] operand;
  logic [7:0] flagsIn;
  logic [2:0] bitSel;
  logic [7:0] result;
  logic [7:0] flagsOut;
  logic writesReg;
  modport core (output op, operand, flagsIn, bitSel,
                input result, flagsOut, writesReg);
  modport alu (input op, operand, flagsIn, bitSel,
               output result, flagsOut, writesReg);
endinterface
`default_nettype wire

/* File: core/bsfie_alu.sv */
// module: shift, rotate, bit transfer and flag arithmetic (combinational)
`timescale 1ns/100ps
`default_nettype none
module bsfie_alu
  import bsfie_pkg::*;
(
  bsfie_alu_if.alu p
);

  // result and flag computation; flags pass through unless the op owns them
  always_comb begin
    logic [7:0] a;
    logic [7:0] res;
    logic [7:0] fl;
    logic carry;
    logic shiftOp;
    a = p.operand;
    res = a;
    fl = p.flagsIn;
    carry = 1'b0;
    shiftOp = 1'b0;
    p.writesReg = 1'b0;
    case (p.op)
      OP_SHIFT_LEFT_LOGICAL: begin
        res = {a[6:0], 1'b0};
        carry = a[7];
        shiftOp = 1'b1;
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        res = {1'b0, a[7:1]};
        carry = a[0];
        shiftOp = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY: begin
        res = {a[6:0], p.flagsIn[FLAG_C]};
        carry = a[7];
        shiftOp = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY: begin
        res = {p.flagsIn[FLAG_C], a[7:1]};
        carry = a[0];
        shiftOp = 1'b1;
      end
      OP_ARITH_SHIFT_RIGHT: begin
        res = {a[7], a[7:1]};
        carry = a[0];
        shiftOp = 1'b1;
      end
      OP_SWAP_NIBBLES: begin
        res = {a[3:0], a[7:4]};
        p.writesReg = 1'b1;
      end
      OP_STORE_BIT_TO_FLAG: begin
        fl[FLAG_T] = a[p.bitSel];
      end
      OP_LOAD_BIT_FROM_FLAG: begin
        res[p.bitSel] = p.flagsIn[FLAG_T];
        p.writesReg = 1'b1;
      end
      // one pair covers overflow, half carry, signed and the rest
      OP_FLAG_SET: fl[p.bitSel] = 1'b1;
      OP_FLAG_CLEAR: fl[p.bitSel] = 1'b0;
      default: res = a; // every other op leaves flags alone
    endcase
    // shared flag update of the shift and rotate group
    if (shiftOp) begin
      p.writesReg = 1'b1;
      fl[FLAG_C] = carry;
      fl[FLAG_Z] = (res == 8'h00);
      fl[FLAG_N] = res[7];
      fl[FLAG_V] = res[7] ^ carry;
    end
    p.result = res;
    p.flagsOut = fl;
  end

endmodule // bsfie_alu
`default_nettype wire

/* File: core/bsfie_top.sv */
// module: bit, shift and flag instruction executor with an AHB-Lite slave
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module bsfie_top
  import bsfie_pkg::*;
#(
  parameter int NUM_REGS = 32,
  parameter int NUM_IO = 32,
  parameter int STACK_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic sleepReq,
  output logic watchdogKick,
  output logic debugHalt
);

  localparam int RW = $clog2(NUM_REGS);
  localparam int IW = $clog2(NUM_IO);
  localparam int SW = $clog2(STACK_DEPTH);

  // indices come from 5-bit command fields and must cover whole arrays
  if (NUM_REGS < 2 || NUM_REGS > 32 || (NUM_REGS & (NUM_REGS - 1)) != 0 ||
      NUM_IO < 2 || NUM_IO > 32 || (NUM_IO & (NUM_IO - 1)) != 0 ||
      STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_chk
    $error("bsfie_top: sizes must be powers of two, arrays at most 32");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HALT} bsfie_state_e;

  bsfie_state_e state_r;
  logic [1:0] execCnt_r;
  logic [31:0] cmd_r;
  logic [7:0] regs_r [NUM_REGS];
  logic [7:0] io_r [NUM_IO];
  logic [7:0] stack_r [STACK_DEPTH];
  logic [SW-1:0] sp_r;
  logic [7:0] flags_r;
  logic wrPend_r;
  logic [11:0] wrAddr_r;
  logic rdCapture;
  logic [31:0] rdVal;

  bsfie_alu_if aluBus ();

  // command fields; cmd_r holds still for the whole instruction
  logic [4:0] cmdOp;
  logic [RW-1:0] rdIdx;
  logic [IW-1:0] ioIdx;
  logic [2:0] bitSel;
  assign cmdOp = cmd_r[CMD_OP_LSB +: 5];
  assign rdIdx = cmd_r[CMD_RD_LSB +: RW];
  assign ioIdx = cmd_r[CMD_IO_LSB +: IW];
  assign bitSel = cmd_r[CMD_BIT_LSB +: 3];

  // bus decode: zero-wait slave, writes land at the end of the data phase
  logic addrPhase;
  logic busWr;
  logic cmdAccept;
  logic regHitW;
  logic ioHitW;
  assign addrPhase = hsel & hready & htrans[1];
  assign busWr = wrPend_r;
  assign cmdAccept = busWr && wrAddr_r == ADDR_CMD && state_r == ST_IDLE;
  assign regHitW = busWr && wrAddr_r[11:8] == PAGE_REGS &&
                   wrAddr_r[7:2] < 6'(NUM_REGS);
  assign ioHitW = busWr && wrAddr_r[11:8] == PAGE_IO &&
                  wrAddr_r[7:2] < 6'(NUM_IO);

  // the instruction takes effect on the edge ending its last cycle
  logic applyNow;
  assign applyNow = state_r == ST_EXEC && execCnt_r == CYC_ONE;

  assign aluBus.op = cmdOp;
  assign aluBus.operand = regs_r[rdIdx];
  assign aluBus.flagsIn = flags_r;
  assign aluBus.bitSel = bitSel;

  bsfie_alu u_alu (
    .p(aluBus.alu)
  );

  // address-phase capture; only whole-word writes are honoured
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 12'h000;
    end else begin
      wrPend_r <= addrPhase && hwrite && hsize == 3'h2;
      wrAddr_r <= {haddr[11:2], 2'b00};
    end
  end

  // read mux, sampled in the address phase so hrdata is a flop
  always_comb begin
    rdVal = 32'h0000_0000;
    if (haddr[11:0] == ADDR_CMD) begin
      rdVal = cmd_r;
    end else if (haddr[11:0] == ADDR_STATUS) begin
      rdVal[STAT_BUSY] = state_r == ST_EXEC;
      rdVal[STAT_HALT] = state_r == ST_HALT;
    end else if (haddr[11:0] == ADDR_FLAGS) begin
      rdVal[7:0] = flags_r;
    end else if (haddr[11:0] == ADDR_SP) begin
      rdVal[SW-1:0] = sp_r;
    end else if (haddr[11:8] == PAGE_REGS && haddr[7:2] < 6'(NUM_REGS)) begin
      rdVal[7:0] = regs_r[haddr[2 +: RW]];
    end else if (haddr[11:8] == PAGE_IO && haddr[7:2] < 6'(NUM_IO)) begin
      rdVal[7:0] = io_r[haddr[2 +: IW]];
    end
  end
  assign rdCapture = addrPhase && !hwrite;

  // bus answer flops; unmapped reads give zero, response is always OKAY
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rdCapture) begin
        hrdata <= rdVal;
      end
    end
  end

  // sequencer: commands written while busy or halted are dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      execCnt_r <= CYC_ONE;
      cmd_r <= CMD_RST;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cmdAccept) begin
            cmd_r <= hwdata;
            state_r <= ST_EXEC;
            case (hwdata[CMD_OP_LSB +: 5])
              OP_PUSH, OP_POP, OP_SET_IO_BIT, OP_CLEAR_IO_BIT:
                execCnt_r <= CYC_TWO;
              default: execCnt_r <= CYC_ONE;
            endcase
          end
        end
        ST_EXEC: begin
          if (applyNow) begin
            // break parks until software writes the resume bit
            state_r <= (cmdOp == OP_BREAK) ? ST_HALT : ST_IDLE;
          end else begin
            execCnt_r <= execCnt_r - 2'h1;
          end
        end
        ST_HALT: begin
          if (busWr && wrAddr_r == ADDR_STATUS && hwdata[STAT_HALT]) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // working registers; an executing instruction wins over a bus write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else if (applyNow && aluBus.writesReg) begin
      regs_r[rdIdx] <= aluBus.result;
    end else if (applyNow && cmdOp == OP_POP) begin
      regs_r[rdIdx] <= stack_r[sp_r + 1'b1];
    end else if (regHitW) begin
      regs_r[wrAddr_r[2 +: RW]] <= hwdata[7:0];
    end
  end

  // I/O registers: read-modify-write of one bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_IO; i++) begin
        io_r[i] <= 8'h00;
      end
    end else if (applyNow && cmdOp == OP_SET_IO_BIT) begin
      io_r[ioIdx][bitSel] <= 1'b1;
    end else if (applyNow && cmdOp == OP_CLEAR_IO_BIT) begin
      io_r[ioIdx][bitSel] <= 1'b0;
    end else if (ioHitW) begin
      io_r[wrAddr_r[2 +: IW]] <= hwdata[7:0];
    end
  end

  // stack grows down from the top index; overflow wraps silently
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_r <= '1;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= 8'h00;
      end
    end else if (applyNow && cmdOp == OP_PUSH) begin
      stack_r[sp_r] <= regs_r[rdIdx];
      sp_r <= sp_r - 1'b1;
    end else if (applyNow && cmdOp == OP_POP) begin
      sp_r <= sp_r + 1'b1;
    end
  end

  // status flags; the unit passes them through for flag-neutral ops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= FLAGS_RST;
    end else if (applyNow) begin
      flags_r <= aluBus.flagsOut;
    end else if (busWr && wrAddr_r == ADDR_FLAGS) begin
      flags_r <= hwdata[7:0];
    end
  end

  // requests to neighbouring units: one-cycle pulses and a halt level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleepReq <= 1'b0;
      watchdogKick <= 1'b0;
      debugHalt <= 1'b0;
    end else begin
      sleepReq <= applyNow && cmdOp == OP_SLEEP;
      watchdogKick <= applyNow && cmdOp == OP_WATCHDOG_KICK;
      if (applyNow && cmdOp == OP_BREAK) begin
        debugHalt <= 1'b1;
      end else if (state_r != ST_HALT) begin
        debugHalt <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_two_cycle;
    state_r == ST_EXEC [*2] ##1 state_r == ST_IDLE;
  endsequence
  sequence s_one_cycle;
    state_r == ST_EXEC ##1 state_r == ST_IDLE;
  endsequence

  chk_io_set_bit: assert property (
    applyNow && cmdOp == OP_SET_IO_BIT |=> io_r[ioIdx][bitSel] &&
      flags_r == $past(flags_r))
    else $error("set-io-bit did not set the bit or moved flags");
  chk_io_clear_bit: assert property (
    applyNow && cmdOp == OP_CLEAR_IO_BIT |=> !io_r[ioIdx][bitSel])
    else $error("clear-io-bit did not clear the bit");
  chk_push_timing: assert property (
    cmdAccept && hwdata[4:0] == OP_PUSH |=> s_two_cycle)
    else $error("push did not take two cycles");
  chk_push_stack: assert property (
    applyNow && cmdOp == OP_PUSH |=> sp_r == $past(sp_r) - 1'b1 &&
      stack_r[sp_r + 1'b1] == regs_r[rdIdx])
    else $error("push did not store the register");
  chk_pop_load: assert property (
    applyNow && cmdOp == OP_POP |=> regs_r[rdIdx] == stack_r[sp_r] &&
      flags_r == $past(flags_r))
    else $error("pop did not load the register");
  chk_shl_result: assert property (
    applyNow && cmdOp == OP_SHIFT_LEFT_LOGICAL |=>
      regs_r[rdIdx] == {$past(aluBus.operand[6:0]), 1'b0} &&
      flags_r[FLAG_C] == $past(aluBus.operand[7]))
    else $error("left shift result or carry wrong");
  chk_rotr_carry: assert property (
    applyNow && cmdOp == OP_ROTATE_RIGHT_CARRY |=>
      regs_r[rdIdx][7] == $past(flags_r[FLAG_C]) &&
      flags_r[FLAG_C] == $past(aluBus.operand[0]))
    else $error("rotate right through carry wrong");
  chk_ashr_sign: assert property (
    applyNow && cmdOp == OP_ARITH_SHIFT_RIGHT |=>
      regs_r[rdIdx][7:6] == {2{$past(aluBus.operand[7])}} &&
      flags_r[FLAG_V] == (flags_r[FLAG_N] ^ flags_r[FLAG_C]))
    else $error("arithmetic shift lost the sign");
  // the mask needs its own parentheses: == binds tighter than &
  chk_tflag_store: assert property (
    applyNow && cmdOp == OP_STORE_BIT_TO_FLAG |=>
      ((flags_r ^ $past(flags_r)) & 8'hBF) == 8'h00 &&
      flags_r[FLAG_T] == $past(aluBus.operand[bitSel]))
    else $error("bit store touched other flags");
  chk_flag_single: assert property (
    cmdAccept && hwdata[4:0] == OP_FLAG_SET |=> s_one_cycle and
      ##1 flags_r[cmd_r[18:16]])
    else $error("flag set not done in one cycle");
  chk_break_halt: assert property (
    applyNow && cmdOp == OP_BREAK |=> debugHalt && state_r == ST_HALT &&
      flags_r == $past(flags_r))
    else $error("break did not halt cleanly");
  chk_sleep_pulse: assert property (
    applyNow && cmdOp == OP_SLEEP |=> sleepReq ##1 !sleepReq)
    else $error("sleep request not a single pulse");

endmodule // bsfie_top
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the bit, shift and flag executor
`timescale 1ns/100ps
`default_nettype none
module testbench import bsfie_pkg::*;;
  localparam logic [31:0] AC = {20'h0, ADDR_CMD};
  localparam logic [31:0] AST = {20'h0, ADDR_STATUS};
  localparam logic [31:0] AF = {20'h0, ADDR_FLAGS};
  localparam logic [31:0] ASP = {20'h0, ADDR_SP};
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic hsel, hwrite, hready, hreadyout, hresp;
  logic sleepReq, watchdogKick, debugHalt;
  logic [1:0] htrans;
  logic [2:0] hsize, b, b2;
  logic [31:0] haddr, hwdata, hrdata;
  logic rdPend = 1'h0;
  logic [31:0] expQ[$];
  logic [7:0] fl, v, w;
  logic [4:0] op, r;
  logic [15:0] ex;
  int numErrors = 0;
  int checksDone = 0;
  int seed = 79;
  int cycles = 0;
  int sleepCnt = 0;
  int kickCnt = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #4 clk = ~clk;

  bsfie_top dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sleepReq(sleepReq), .watchdogKick(watchdogKick),
    .debugHalt(debugHalt));

  task automatic endOfTest;
    $display("errors %0d checks %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checksDone++;
    if (g !== e) begin
      numErrors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // one word transfer; a noted read queues its expected value
  task automatic xfer(input logic [31:0] a, input logic wr,
                      input logic [31:0] d, input bit note,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wr ? d : 32'h0;
    rdPend <= note & ~wr;
    if (note && !wr) expQ.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'h1);
    q = hrdata;
    rdPend <= 1'h0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'h1, d, 1'b0, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'h0, e, 1'b1, q);
  endtask

  // launch a command, then poll the status register until the busy bit reads zero
  task automatic exec(input logic [4:0] o, input logic [4:0] rr,
                      input logic [2:0] bb, input logic [4:0] io);
    logic [31:0] q;
    wr(AC, {3'h0, io, 5'h0, bb, 3'h0, rr, 3'h0, o});
    q = 32'h1;
    while (q[STAT_BUSY] !== 1'h0) xfer(AST, 1'h0, 32'h0, 1'b0, q);
  endtask

  function automatic logic [31:0] ra(input int i);
    return 32'h100 + 32'(4 * i);
  endfunction

  function automatic logic [31:0] ia(input int i);
    return 32'h200 + 32'(4 * i);
  endfunction

  // expected {flags, result}; only Z C N V move on a shift
  function automatic logic [15:0] shexp(input logic [4:0] o,
      input logic [7:0] x, input logic [7:0] f);
    logic [7:0] y;
    logic c;
    c = x[0];
    case (o)
      OP_SHIFT_LEFT_LOGICAL: begin
        y = {x[6:0], 1'h0};
        c = x[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: y = {1'h0, x[7:1]};
      OP_ROTATE_LEFT_CARRY: begin
        y = {x[6:0], f[FLAG_C]};
        c = x[7];
      end
      OP_ROTATE_RIGHT_CARRY: y = {f[FLAG_C], x[7:1]};
      OP_ARITH_SHIFT_RIGHT: y = {x[7], x[7:1]};
      default: return {f, x[3:0], x[7:4]};
    endcase
    f[FLAG_C] = c;
    f[FLAG_Z] = (y == 8'h00);
    f[FLAG_N] = y[7];
    f[FLAG_V] = y[7] ^ c;
    return {f, y};
  endfunction

  // result watcher: oldest note against each noted read's data phase
  always @(posedge clk) begin
    if (rdPend === 1'h1 && hreadyout === 1'h1) begin
      cmp(hrdata, expQ.pop_front(), "read data");
      cmp({31'h0, hresp}, 32'h0, "response");
    end
    if (sleepReq === 1'h1) sleepCnt++;
    if (watchdogKick === 1'h1) kickCnt++;
  end

  // hang guard, far above the fewer than one thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      $display("[FAIL] %0t timeout", $time);
      endOfTest();
    end
  end

  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    // reset values and an unmapped place
    rd(AF, {24'h0, FLAGS_RST});
    rd(ASP, 32'hF);
    rd(AC, CMD_RST);
    rd(ra(31), 32'h0);
    wr(32'h300, $random(seed));
    rd(32'h300, 32'h0);
    // every flag set and cleared on its own
    fl = 8'($random(seed));
    wr(AF, {24'h0, fl});
    for (int s = 0; s < 8; s++) begin
      exec(OP_FLAG_SET, 5'h0, 3'(s), 5'h0);
      fl[s] = 1'h1;
      rd(AF, {24'h0, fl});
      exec(OP_FLAG_CLEAR, 5'h0, 3'(s), 5'h0);
      fl[s] = 1'h0;
      rd(AF, {24'h0, fl});
    end
    // shifts, rotates and swap on 8'h80 then random operands, with random carries
    for (int k = 0; k < 18; k++) begin
      op = 5'(5 + k % 6);
      r = 5'($random(seed));
      v = (k < 6) ? 8'h80 : 8'($random(seed));
      fl = 8'($random(seed));
      wr(ra(r), {24'h0, v});
      wr(AF, {24'h0, fl});
      exec(op, r, 3'h0, 5'h0);
      ex = shexp(op, v, fl);
      rd(ra(r), {24'h0, ex[7:0]});
      rd(AF, {24'h0, ex[15:8]});
    end
    // bit moved into the transfer flag and back out
    for (int k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      b = 3'($random(seed));
      b2 = 3'($random(seed));
      wr(ra(4), {24'h0, v});
      wr(ra(5), {24'h0, w});
      exec(OP_STORE_BIT_TO_FLAG, 5'h4, b, 5'h0);
      fl[FLAG_T] = v[b];
      rd(AF, {24'h0, fl});
      exec(OP_LOAD_BIT_FROM_FLAG, 5'h5, b2, 5'h0);
      w[b2] = fl[FLAG_T];
      rd(ra(5), {24'h0, w});
      rd(AF, {24'h0, fl});
    end
    // io bit set and clear on the top io slot, then a no-op
    v = 8'($random(seed));
    b = 3'($random(seed));
    wr(ia(31), {24'h0, v});
    exec(OP_SET_IO_BIT, 5'h0, b, 5'h1F);
    v[b] = 1'h1;
    rd(ia(31), {24'h0, v});
    exec(OP_CLEAR_IO_BIT, 5'h0, b + 3'h1, 5'h1F);
    v[b + 3'h1] = 1'h0;
    rd(ia(31), {24'h0, v});
    exec(OP_NOP, 5'h0, 3'h0, 5'h1F);
    rd(ia(31), {24'h0, v});
    rd(AF, {24'h0, fl});
    // two pushes then two pops come back in reverse order
    v = 8'($random(seed));
    w = 8'($random(seed));
    wr(ra(1), {24'h0, v});
    wr(ra(2), {24'h0, w});
    exec(OP_PUSH, 5'h1, 3'h0, 5'h0);
    exec(OP_PUSH, 5'h2, 3'h0, 5'h0);
    rd(ASP, 32'hD);
    exec(OP_POP, 5'h3, 3'h0, 5'h0);
    exec(OP_POP, 5'h4, 3'h0, 5'h0);
    rd(ra(3), {24'h0, w});
    rd(ra(4), {24'h0, v});
    rd(ASP, 32'hF);
    rd(AF, {24'h0, fl});
    // request pulses to the sleep and watchdog units
    exec(OP_SLEEP, 5'h0, 3'h0, 5'h0);
    exec(OP_WATCHDOG_KICK, 5'h0, 3'h0, 5'h0);
    repeat (2) @(posedge clk);
    cmp(32'(sleepCnt), 32'h1, "sleep pulses");
    cmp(32'(kickCnt), 32'h1, "kick pulses");
    // break halts; a command while halted is dropped until resume
    wr(ra(6), 32'h81);
    exec(OP_BREAK, 5'h0, 3'h0, 5'h0);
    rd(AST, 32'h2);
    cmp({31'h0, debugHalt}, 32'h1, "halt level");
    exec(OP_SHIFT_LEFT_LOGICAL, 5'h6, 3'h0, 5'h0);
    rd(ra(6), 32'h81);
    wr(AST, 32'h2);
    rd(AST, 32'h0);
    cmp({31'h0, debugHalt}, 32'h0, "halt released");
    rd(AF, {24'h0, fl});
    repeat (2) @(posedge clk);
    endOfTest();
  end
endmodule // testbench
`default_nettype wire
